//--- src/bank_cfg.svh
// Register map offsets, field positions and reset values of the bridge register bank.
`ifndef BANK_CFG_SVH
`define BANK_CFG_SVH
`define ADDR_FAULT_SUM   5'h00
`define ADDR_DIAG        5'h01
`define ADDR_DRIVE_CFG   5'h02
`define ADDR_PROT_CFG    5'h03
`define ADDR_CLR_LOCK    5'h04
`define ADDR_LOAD_CFG    5'h05
`define RST_DRIVE_CFG    8'h51
`define RST_PROT_CFG     8'h0c
`define RST_CLR_LOCK     8'h40
`define RST_LOAD_CFG     8'h08
`define FRAME_BITS       5'h10
`define ADDR_DONE_CNT    5'h06
`define FRM_RW_BIT       14
`define FRM_ADDR_HI      13
`define FRM_ADDR_LO      9
`define CLR_BIT          7
`define SUM_FAULT_BIT    6
`define STATUS_HEAD      2'h3
`define CLR_MASK         8'h7f
`define SUM_ZERO_MASK    8'h7f
`define PROT_OTW_REP     5
`define PROT_ITRIP_REP   7
`define CFG_SRC_BIT      5
`define CFG_MODE_HI      1
`define CFG_MODE_LO      0
`define CFG_SLEW_HI      4
`define CFG_SLEW_LO      2
`define CFG_OFF_TIME_SELECT_HI      7
`define CFG_OFF_TIME_SELECT_LO      6
`define OFF_TIME_SELECT_UNIT_US     20
`define OFF_TIME_SELECT_UNIT_CYC    (`OFF_TIME_SELECT_UNIT_US * 1000 / 10)
`endif

//--- src/bank_pkg.sv
// Types shared by the bridge register bank.
package bank_pkg;
	typedef enum logic [1:0] {
		PHASE_ENABLE_SCHEME = 2'b00,
		PWM_SCHEME          = 2'b01,
		HALF_BRIDGE_SCHEME  = 2'b10,
		HIZ_SCHEME          = 2'b11
	} scheme_t;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_WAIT  = 2'b10
	} frame_state_t;
	typedef struct packed {
		frame_state_t fsm;
		logic [4:0]   cnt;
		logic [15:0]  rx;
		logic [15:0]  tx;
		logic         sdo;
		logic         sdo_oe_n;
		logic [5:0]   latched;
		logic [5:0]   diag_lat;
		logic [7:0]   drive_cfg;
		logic [7:0]   prot_cfg;
		logic [7:0]   clr_lock;
		logic [7:0]   load_cfg;
		logic         fault_out_n;
		logic         out_a;
		logic         out_b;
		logic         hiz;
	} bank_state_t;
endpackage

//--- src/motor_bridge_register_bank.sv
// Serial-frame register bank with fault latching for the brushed-motor bridge.
`include "bank_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module motor_bridge_register_bank #(
	parameter int OFF_TIME_SELECT_UNIT_CYCLES = `OFF_TIME_SELECT_UNIT_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       sel_n,
	input  wire logic       sclk,
	input  wire logic       sdi,
	output logic            sdo,
	output logic            sdo_oe_n,
	input  wire logic       overtemp_warning_flag,
	input  wire logic       supply_undervoltage_flag,
	input  wire logic       pump_undervoltage_flag,
	input  wire logic       thermal_shutdown_flag,
	input  wire logic       open_load_bridge_a,
	input  wire logic       open_load_bridge_b,
	input  wire logic       regulating_bridge_a,
	input  wire logic       regulating_bridge_b,
	input  wire logic       overcurrent_high_a,
	input  wire logic       overcurrent_low_a,
	input  wire logic       overcurrent_high_b,
	input  wire logic       overcurrent_low_b,
	input  wire logic       pin_in_a,
	input  wire logic       pin_in_b,
	output logic            fault_output_pin_n,
	output logic            bridge_in_a,
	output logic            bridge_in_b,
	output logic            bridge_hiz,
	output logic [7:0]      drive_cfg,
	output logic [7:0]      prot_cfg,
	output logic [7:0]      load_cfg
);
	bank_pkg::bank_state_t s_r;
	bank_pkg::bank_state_t s_nxt;
	logic sclk_d_r;
	logic fall;
	logic rise;
	logic overcurrent_flag;
	logic [7:0] fault_sum;
	logic [7:0] diag_val;
	logic [7:0] rd_val;
	logic [4:0] addr;
	logic [5:0] raw_fault;
	logic [5:0] raw_diag;
	logic any_fault;

	// -----------------------------------------------------------------
	// Status assembly
	// -----------------------------------------------------------------
	// Fault and overcurrent events latch until cleared; current regulation is live.
	assign overcurrent_flag = overcurrent_high_a | overcurrent_low_a | overcurrent_high_b | overcurrent_low_b;
	assign raw_fault = {overtemp_warning_flag, supply_undervoltage_flag, pump_undervoltage_flag,
		overcurrent_flag, thermal_shutdown_flag, open_load_bridge_a | open_load_bridge_b};
	assign raw_diag = {open_load_bridge_a, open_load_bridge_b, overcurrent_high_a, overcurrent_low_a,
		overcurrent_high_b, overcurrent_low_b};
	// Overtemp warning and regulation count as faults only when their report bits are set.
	assign any_fault = (|s_r.latched[4:0]) | (s_r.latched[5] & s_r.prot_cfg[`PROT_OTW_REP])
		| ((regulating_bridge_a | regulating_bridge_b) & s_r.prot_cfg[`PROT_ITRIP_REP]);
	assign fault_sum = {1'b0, ~s_r.fault_out_n, s_r.latched};
	assign diag_val = {s_r.diag_lat[5:4], regulating_bridge_a, regulating_bridge_b,
		s_r.diag_lat[3:0]};
	// While waiting only seven bits are in, so the address still sits at the bottom of the shifter.
	assign addr = (s_r.fsm == bank_pkg::ST_WAIT) ? s_r.rx[`FRM_ADDR_HI-`FRM_ADDR_LO:0]
		: s_r.rx[`FRM_ADDR_HI:`FRM_ADDR_LO];

	always_comb begin
		unique case (addr)
			`ADDR_FAULT_SUM: rd_val = fault_sum;
			`ADDR_DIAG:      rd_val = diag_val;
			`ADDR_DRIVE_CFG: rd_val = s_r.drive_cfg;
			`ADDR_PROT_CFG:  rd_val = s_r.prot_cfg;
			`ADDR_CLR_LOCK:  rd_val = s_r.clr_lock;
			`ADDR_LOAD_CFG:  rd_val = s_r.load_cfg;
			default:         rd_val = 8'h00;
		endcase
	end

	// -----------------------------------------------------------------
	// Serial edge detection
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk;
		end
	end
	assign fall = sclk_d_r & ~sclk;
	assign rise = ~sclk_d_r & sclk;

	// -----------------------------------------------------------------
	// Frame engine and registers
	// -----------------------------------------------------------------
	// The address is only known after bit 9 arrives, so the answer byte is
	// loaded then; the status byte is captured at frame start.
	always_comb begin
		s_nxt = s_r;
		s_nxt.latched = s_r.latched | raw_fault;
		s_nxt.diag_lat = s_r.diag_lat | raw_diag;
		unique case (s_r.fsm)
			bank_pkg::ST_IDLE: begin
				s_nxt.sdo_oe_n = 1'b1;
				if (!sel_n) begin
					s_nxt.fsm = bank_pkg::ST_SHIFT;
					s_nxt.cnt = 5'h00;
					s_nxt.tx = {`STATUS_HEAD, fault_sum[5:0], 8'h00};
					s_nxt.sdo = s_nxt.tx[15];
					s_nxt.sdo_oe_n = 1'b0;
				end
			end
			bank_pkg::ST_SHIFT: begin
				if (sel_n) begin
					// Whole frames only: a short or long frame changes nothing.
					if (s_r.cnt == `FRAME_BITS && !s_r.rx[`FRM_RW_BIT]) begin
						unique case (addr)
							`ADDR_DRIVE_CFG: s_nxt.drive_cfg = s_r.rx[7:0];
							`ADDR_PROT_CFG:  s_nxt.prot_cfg = s_r.rx[7:0];
							`ADDR_CLR_LOCK: begin
								s_nxt.clr_lock = s_r.rx[7:0] & `CLR_MASK;
								if (s_r.rx[`CLR_BIT]) begin
									// Events present now still set the flags: set wins.
									s_nxt.latched = raw_fault;
									s_nxt.diag_lat = raw_diag;
								end
							end
							`ADDR_LOAD_CFG:  s_nxt.load_cfg = s_r.rx[7:0];
							default: ;
						endcase
					end
					s_nxt.fsm = bank_pkg::ST_IDLE;
					s_nxt.sdo_oe_n = 1'b1;
				end else begin
					if (fall) begin
						s_nxt.rx = {s_r.rx[14:0], sdi};
						if (s_r.cnt != 5'h1f) begin
							s_nxt.cnt = s_r.cnt + 5'h01;
						end
					end
					if (rise) begin
						s_nxt.tx = {s_r.tx[14:0], 1'b0};
						s_nxt.sdo = s_r.tx[14];
					end
					// The last address bit lands on the seventh fall, before the report MSB must leave.
					if (s_r.cnt == `ADDR_DONE_CNT && fall) begin
						s_nxt.fsm = bank_pkg::ST_WAIT;
					end
				end
			end
			bank_pkg::ST_WAIT: begin
				// One cycle after the last address bit is taken the report byte is loaded.
				s_nxt.tx[14:7] = rd_val;
				s_nxt.fsm = sel_n ? bank_pkg::ST_IDLE : bank_pkg::ST_SHIFT;
				s_nxt.sdo_oe_n = sel_n;
			end
			default: s_nxt.fsm = bank_pkg::ST_IDLE;
		endcase
		s_nxt.fault_out_n = ~any_fault;
		s_nxt.hiz = (s_r.drive_cfg[`CFG_MODE_HI:`CFG_MODE_LO] == bank_pkg::HIZ_SCHEME);
		s_nxt.out_a = s_r.drive_cfg[`CFG_SRC_BIT] ? s_r.clr_lock[1] : pin_in_a;
		s_nxt.out_b = s_r.drive_cfg[`CFG_SRC_BIT] ? s_r.clr_lock[0] : pin_in_b;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_r <= '{fsm: bank_pkg::ST_IDLE, cnt: 5'h00, rx: 16'h0000, tx: 16'h0000, sdo: 1'b0,
				sdo_oe_n: 1'b1, latched: 6'h00, diag_lat: 6'h00, drive_cfg: `RST_DRIVE_CFG,
				prot_cfg: `RST_PROT_CFG, clr_lock: `RST_CLR_LOCK, load_cfg: `RST_LOAD_CFG,
				fault_out_n: 1'b1, out_a: 1'b0, out_b: 1'b0, hiz: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sdo = s_r.sdo;
	assign sdo_oe_n = s_r.sdo_oe_n;
	assign fault_output_pin_n = s_r.fault_out_n;
	assign bridge_in_a = s_r.out_a;
	assign bridge_in_b = s_r.out_b;
	assign bridge_hiz = s_r.hiz;
	assign drive_cfg = s_r.drive_cfg;
	assign prot_cfg = s_r.prot_cfg;
	assign load_cfg = s_r.load_cfg;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence frame_end_write(logic [4:0] a);
		s_r.fsm == bank_pkg::ST_SHIFT && sel_n && s_r.cnt == `FRAME_BITS && !s_r.rx[`FRM_RW_BIT] && addr == a;
	endsequence

	a_status_ro_kept: assert property (s_r.fsm == bank_pkg::ST_SHIFT && sel_n && addr == `ADDR_DIAG
		|=> $stable(s_r.drive_cfg) && $stable(s_r.load_cfg)) else $error("status write touched config");
	a_cfg_write_lands: assert property (frame_end_write(`ADDR_DRIVE_CFG)
		|=> s_r.drive_cfg == $past(s_r.rx[7:0])) else $error("config write lost");
	a_sum_bit_pin: assert property (fault_sum[`SUM_FAULT_BIT] == !fault_output_pin_n
		&& !fault_sum[7]) else $error("summary bit differs from pin");
	a_pin_tracks_latch: assert property (|s_r.latched[4:0] |=> !fault_output_pin_n)
		else $error("latched fault not on pin");
	a_flag_latches: assert property (thermal_shutdown_flag |=> s_r.latched[1])
		else $error("shutdown not latched");
	a_regulate_live: assert property (diag_val[5] == regulating_bridge_a
		&& diag_val[4] == regulating_bridge_b) else $error("regulation bits wrong");
	a_clear_self: assert property (frame_end_write(`ADDR_CLR_LOCK) |=> !s_r.clr_lock[`CLR_BIT])
		else $error("clear bit stuck");
	a_short_frame: assert property (s_r.fsm == bank_pkg::ST_SHIFT && sel_n && s_r.cnt != `FRAME_BITS
		|=> $stable(s_r.drive_cfg) && $stable(s_r.prot_cfg) && $stable(s_r.clr_lock))
		else $error("bad frame wrote");
	a_source_select: assert property (s_r.drive_cfg[`CFG_SRC_BIT]
		|=> bridge_in_a == $past(s_r.clr_lock[1])) else $error("register drive not followed");
	a_hiz_scheme: assert property (s_r.drive_cfg[1:0] == bank_pkg::HIZ_SCHEME |=> bridge_hiz)
		else $error("hiz scheme ignored");
endmodule
`default_nettype wire

//--- verification/serial_host.sv
// Behavioural serial host that frames commands for the register bank.
`timescale 1ns/1ns
`default_nettype none
module serial_host (
	input  wire logic        ref_clk,
	input  wire logic        req,
	input  wire logic [15:0] cmd,
	input  wire logic [4:0]  nbits,
	input  wire logic        sdo,
	input  wire logic        sdo_oe_n,
	output logic             sel_n,
	output logic             sclk,
	output logic             sdi,
	output logic             busy,
	output logic             done,
	output logic [15:0]      resp
);
	logic line;
	initial begin
		sel_n = 1'b1;
		{sclk, sdi, busy, done, line, resp} = '0;
	end
	always begin
		@(negedge ref_clk);
		done = 1'b0;
		if (req) begin
			busy = 1'b1;
			sel_n = 1'b0;
			repeat (2) @(negedge ref_clk);
			for (int i = 0; i < nbits; i++) begin
				sdi = cmd[15 - i];
				repeat (2) @(negedge ref_clk);
				// An undriven line must not repeat the last bit, or a dead output would pass.
				line = sdo_oe_n ? ~line : sdo;
				resp[15 - i] = line;
				sclk = 1'b1;
				repeat (2) @(negedge ref_clk);
				sclk = 1'b0;
				// Hold the bit until the bank has seen the falling edge.
				@(negedge ref_clk);
			end
			sdi = ~sdi;
			repeat (2) @(negedge ref_clk);
			sel_n = 1'b1;
			repeat (2) @(negedge ref_clk);
			done = (nbits == 5'h10);
			busy = 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- verification/motor_bridge_register_bank_tb_top.sv
// Self-checking bench for the bridge register bank.
`include "bank_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module motor_bridge_register_bank_tb_top;
	logic        ref_clk, rst, req, sel_n, sclk, sdi, sdo, sdo_oe_n, busy, done;
	logic        fault_output_pin_n, bridge_in_a, bridge_in_b, bridge_hiz;
	logic        pin_in_a, pin_in_b, regulating_bridge_a, regulating_bridge_b;
	logic [4:0]  nbits;
	logic [9:0]  ev;
	logic [7:0]  drive_cfg, prot_cfg, load_cfg, hd, d, shadow;
	logic [15:0] cmd, resp;
	logic [15:0] exp_q[$];
	logic [15:0] tbl [10] = '{16'h2000, 16'h5000, 16'h4800, 16'h4200, 16'h4180,
		16'h4140, 16'h4408, 16'h4404, 16'h4402, 16'h4401};
	logic [7:0]  dflt [8] = '{8'h00, 8'h00, 8'h51, `RST_PROT_CFG, `RST_CLR_LOCK, `RST_LOAD_CFG, 8'h00, 8'h00};
	int          err_count, cmp_count;
	motor_bridge_register_bank #(.OFF_TIME_SELECT_UNIT_CYCLES(4)) dut_u (
		.ref_clk, .rst, .sel_n, .sclk, .sdi, .sdo, .sdo_oe_n,
		.overtemp_warning_flag(ev[0]), .supply_undervoltage_flag(ev[1]),
		.pump_undervoltage_flag(ev[2]), .thermal_shutdown_flag(ev[3]),
		.open_load_bridge_a(ev[4]), .open_load_bridge_b(ev[5]),
		.overcurrent_high_a(ev[6]), .overcurrent_low_a(ev[7]),
		.overcurrent_high_b(ev[8]), .overcurrent_low_b(ev[9]),
		.regulating_bridge_a, .regulating_bridge_b, .pin_in_a, .pin_in_b,
		.fault_output_pin_n, .bridge_in_a, .bridge_in_b, .bridge_hiz,
		.drive_cfg, .prot_cfg, .load_cfg);
	serial_host host_u (.ref_clk, .req, .cmd, .nbits, .sdo, .sdo_oe_n,
		.sel_n, .sclk, .sdi, .busy, .done, .resp);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		if (err_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	function automatic logic [15:0] mk(input logic rd, input logic [4:0] a, input logic [7:0] v);
		return {1'b0, rd, a, 1'b0, v};
	endfunction
	// Notes the answer of a 16-bit frame, runs one frame and waits, bounded, for the host to finish.
	task automatic frame(input logic [15:0] c, input logic [4:0] n, input logic [15:0] e);
		int k;
		if (n == 5'h10)
			exp_q.push_back(e);
		cmd <= c;
		nbits <= n;
		req <= 1'b1;
		@(negedge ref_clk);
		req <= 1'b0;
		for (k = 0; k < 300 && (k < 2 || busy); k++)
			@(negedge ref_clk);
		if (busy) begin
			err_count++;
			$display("[FAIL] %0t host timed out", $time);
			give_verdict();
		end
	endtask
	always @(posedge ref_clk) begin
		if (done === 1'b1) begin
			if (exp_q.size() == 0)
				chk(resp, ~resp);
			else
				chk(resp, exp_q.pop_front());
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst, req, ev, cmd, nbits, regulating_bridge_a, regulating_bridge_b, pin_in_a, pin_in_b} = '0;
		rst = 1'b1;
		err_count = 0;
		cmp_count = 0;
		shadow = 8'($urandom(32'he867));
		repeat (8) @(negedge ref_clk);
		rst <= 1'b0;
		@(negedge ref_clk);
		for (int i = 0; i < 8; i++)
			frame(mk(1'b1, (i == 7) ? 5'h1f : 5'(i), 8'h00), 5'h10, {8'hc0, dflt[i]});
		chk({15'h0, fault_output_pin_n}, 16'h0001);
		for (int i = 0; i < 3; i++) begin
			frame(mk(1'b0, 5'(i % 2), 8'hff), 5'h10, 16'hc000);
			frame(mk(1'b1, (i == 2) ? 5'h0a : 5'(i), 8'h00), 5'h10, 16'hc000);
		end
		shadow = 8'h51;
		for (int m = 0; m < 4; m++) begin
			d = 8'($urandom());
			d[5] = 1'b0;
			d[1:0] = 2'(m);
			pin_in_a <= d[7];
			pin_in_b <= d[6];
			frame(mk(1'b0, 5'h02, d), 5'h10, {8'hc0, shadow});
			shadow = d;
			chk({drive_cfg, 5'h0, bridge_hiz, bridge_in_a, bridge_in_b}, {d, 5'h0, m == 3, d[7], d[6]});
		end
		frame(mk(1'b1, 5'h02, 8'h00), 5'h10, {8'hc0, shadow});
		pin_in_a <= 1'b0;
		pin_in_b <= 1'b1;
		frame(mk(1'b0, 5'h02, 8'h61), 5'h10, {8'hc0, shadow});
		frame(mk(1'b0, 5'h04, 8'h42), 5'h10, {8'hc0, 8'h40});
		chk({14'h0, bridge_in_a, bridge_in_b}, 16'h0002);
		d = 8'($urandom());
		frame(mk(1'b0, 5'h05, d), 5'h10, {8'hc0, 8'h08});
		frame(mk(1'b1, 5'h05, 8'h00), 5'h10, {8'hc0, d});
		chk({load_cfg, prot_cfg}, {d, 8'h0c});
		frame(mk(1'b0, 5'h03, 8'hff), 5'h0f, 16'h0000);
		frame(mk(1'b1, 5'h03, 8'h00), 5'h10, {8'hc0, 8'h0c});
		for (int i = 0; i < 10; i++) begin
			ev <= 10'(1) << i;
			@(negedge ref_clk);
			ev <= '0;
			@(negedge ref_clk);
			hd = {2'b11, tbl[i][13:8]};
			frame(mk(1'b1, 5'h00, 8'h00), 5'h10, {hd, tbl[i][15:8]});
			chk({15'h0, fault_output_pin_n}, {15'h0, ~tbl[i][14]});
			frame(mk(1'b1, 5'h01, 8'h00), 5'h10, {hd, tbl[i][7:0]});
			frame(mk(1'b0, 5'h04, 8'hc2), 5'h10, {hd, 8'h42});
			frame(mk(1'b1, 5'h00, 8'h00), 5'h10, 16'hc000);
		end
		frame(mk(1'b1, 5'h04, 8'h00), 5'h10, 16'hc042);
		regulating_bridge_a <= 1'b1;
		frame(mk(1'b1, 5'h01, 8'h00), 5'h10, 16'hc020);
		regulating_bridge_a <= 1'b0;
		regulating_bridge_b <= 1'b1;
		frame(mk(1'b1, 5'h01, 8'h00), 5'h10, 16'hc010);
		repeat (4) @(negedge ref_clk);
		chk(16'(exp_q.size()), 16'h0000);
		give_verdict();
	end
endmodule
`default_nettype wire
